// [sdma_pkg.sv]
// sdma_pkg: constants, codes and carrier types of the one-channel byte dma
// assumes a paged 8-bit special-function-register bus and one system clock
package sdma_pkg;
  // register addresses on the paged bus
  localparam logic [7:0] ADDR_DMA   = 8'h94;
  localparam logic [7:0] ADDR_TCON  = 8'hc8;
  localparam logic [7:0] ADDR_TRL   = 8'hca;
  localparam logic [7:0] ADDR_TRH   = 8'hcb;
  localparam logic [7:0] ADDR_TCL   = 8'hcc;
  localparam logic [7:0] ADDR_TCH   = 8'hcd;
  // pages: control on 0..7, configuration on 8, path on 9, timers 3 and 4
  localparam logic [3:0] PAGE_CR_LAST = 4'h7;
  localparam logic [3:0] PAGE_CG      = 4'h8;
  localparam logic [3:0] PAGE_DS      = 4'h9;
  localparam logic [3:0] PAGE_CNT     = 4'h3;
  localparam logic [3:0] PAGE_ADR     = 4'h4;
  // dma_control fields
  localparam int CR_EN   = 3;
  localparam int CR_GO   = 2;
  localparam int CR_IE   = 1;
  localparam int CR_DONE = 0;
  localparam logic [7:0] CR_MASK = 8'h0f;
  // dma_configuration fields
  localparam int CG_PRIO_HI = 7;
  localparam int CG_PRIO_LO = 6;
  localparam int CG_CRC     = 5;
  localparam int CG_TRIG_HI = 3;
  localparam int CG_TRIG_LO = 2;
  localparam int CG_LOOP    = 0;
  localparam logic [7:0] CG_MASK = 8'hed;
  // timer control fields
  localparam int TC_TF     = 7;
  localparam int TC_CKS_HI = 5;
  localparam int TC_CKS_LO = 4;
  localparam int TC_IE     = 3;
  localparam int TC_RUN    = 2;
  localparam int TC_GAT_HI = 1;
  localparam int TC_GAT_LO = 0;
  localparam logic [7:0] TC_MASK = 8'hbf;
  // path codes
  localparam logic [3:0] PATH_OFF    = 4'h0;
  localparam logic [3:0] PATH_PERIPH = 4'h7;
  localparam logic [3:0] PATH_ADC    = 4'h9;
  localparam logic [3:0] PATH_EMB    = 4'hb;
  localparam logic [3:0] PATH_CRC    = 4'hd;
  localparam logic [3:0] PATH_EXPANDED_RAM   = 4'hf;
  // trigger, clock and gate selections
  localparam logic [1:0] TRIG_SW   = 2'h0;
  localparam logic [1:0] TRIG_INT2 = 2'h1;
  localparam logic [1:0] TRIG_BRK  = 2'h2;
  localparam logic [1:0] TRIG_KBI  = 2'h3;
  localparam logic [1:0] CKS_DIV12 = 2'h0;
  localparam logic [1:0] CKS_PIN   = 2'h1;
  localparam logic [1:0] CKS_SYS   = 2'h2;
  localparam logic [1:0] CKS_EXT   = 2'h3;
  localparam logic [1:0] GAT_NONE  = 2'h0;
  localparam logic [1:0] GAT_IRQ   = 2'h1;
  localparam logic [1:0] GAT_INT2  = 2'h2;
  localparam logic [1:0] GAT_EXT   = 2'h3;
  // counting constants
  localparam logic [3:0]  PRESC_LAST = 4'hb;
  localparam logic [15:0] CNT_LAST   = 16'hffff;
  localparam logic [15:0] CNT_STEP   = 16'h0001;

  typedef enum logic [1:0] {
    SDMA_IDLE  = 2'b00,
    SDMA_FETCH = 2'b01,
    SDMA_STORE = 2'b11
  } sdma_state_t;

  // register bus request
  typedef struct packed {
    logic [3:0] page;
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } sdma_sfr_req_t;

  // event and pin inputs
  typedef struct packed {
    logic ext_irq0_event;
    logic ext_irq1_event;
    logic ext_irq2_event;
    logic break_mod1_event;
    logic keypad_event;
    logic timer3_ext_input;
    logic timer2_ext_input;
    logic address_pin;
    logic count_pin;
  } sdma_events_t;

  // whole state of the engine
  typedef struct packed {
    logic [7:0]       cr;
    logic [7:0]       cg;
    logic [7:0]       ds;
    logic [1:0][7:0]  tcon;
    logic [1:0][15:0] cnt;
    logic [1:0][15:0] rld;
    logic [3:0]       presc;
    logic [3:0]       pin_prev;
    sdma_state_t      st;
    logic [7:0]       data;
    logic [7:0]       rdata;
    logic             src_rd;
    logic             dst_wr;
    logic             crc_wr;
    logic             irq;
    logic [1:0]       prio;
  } sdma_regs_t;

  localparam sdma_regs_t REGS_RESET = '0;
endpackage : sdma_pkg

// [sdma_engine.sv]
// sdma_engine: one-channel byte dma with transfer-count and address timers
// assumes synchronous inputs, peripherals that hold their ready level and
// a source that drives its byte in the cycle its read strobe is high
//
// Functional notes
// - engine enable bit gates every dma transaction
// - setting transfer go bit starts or resumes a block transfer
// - end of transfer clears go bit unless loop mode is on; software zero only suspends
// - completion flag set at end of transfer, held until written zero
// - completion flag raises shared interrupt when its enable is set
// - configuration bits seven and six carry interrupt priority out
// - checksum copy enable sends each moved byte to the crc unit too
// - trigger field picks software, irq2, break module or keypad start
// - circular mode bit selects loop operation
// - source path field selects the byte source
// - dest path field selects the byte destination
// - count timer clock: system_clock/12, pin, system_clock, timer2 input
// - count timer overflow flag set on overflow, held until cleared
// - count timer overflow flag requests shared interrupt when enabled
// - count timer gate: none, not irq0, not irq2, timer3 input
// - address timer clock: system_clock/12, pin, system_clock, timer3 input
// - address timer overflow flag set on overflow, held until cleared
// - address timer overflow flag requests shared interrupt if enabled
// - address timer gate: none, not irq1, not irq2, timer2 input
// - counter steps per byte; rollover ends transfer and reloads it
// - address steps per ram byte and reloads at end of transfer
// - loop mode reloads both and keeps serving without new go
// - suspend takes effect only after the byte in flight completes
`timescale 1ns/1ps
module sdma_engine (
  input  wire logic                  clk_sys_i,
  input  wire logic                  reset_n_i,
  input  wire logic                  ce_i,
  input  wire sdma_pkg::sdma_sfr_req_t sfr_req_i,
  output logic [7:0]                 sfr_rdata_o,
  input  wire sdma_pkg::sdma_events_t evt_i,
  input  wire logic                  src_ready_i,
  input  wire logic [7:0]            src_data_i,
  input  wire logic                  dst_ready_i,
  output logic [3:0]                 src_sel_o,
  output logic [3:0]                 dst_sel_o,
  output logic                       src_rd_o,
  output logic                       dst_wr_o,
  output logic                       crc_wr_o,
  output logic [7:0]                 xfer_data_o,
  output logic [15:0]                expanded_ram_addr_o,
  output logic                       irq_o,
  output logic [1:0]                 irq_prio_o
);

  sdma_pkg::sdma_regs_t q;
  sdma_pkg::sdma_regs_t n;

  // legal source codes
  function automatic logic src_ok(input logic [3:0] c);
    src_ok = (c != sdma_pkg::PATH_OFF) && ((c <= sdma_pkg::PATH_PERIPH)
           || (c == sdma_pkg::PATH_ADC) || (c == sdma_pkg::PATH_EMB)
           || (c == sdma_pkg::PATH_EXPANDED_RAM));
  endfunction : src_ok

  // legal destination codes
  function automatic logic dst_ok(input logic [3:0] c);
    dst_ok = (c != sdma_pkg::PATH_OFF) && ((c <= sdma_pkg::PATH_PERIPH)
           || (c == sdma_pkg::PATH_CRC) || (c == sdma_pkg::PATH_EMB)
           || (c == sdma_pkg::PATH_EXPANDED_RAM));
  endfunction : dst_ok

  // next-state logic of the whole block
  always_comb begin
    logic       en;
    logic       loop_on;
    logic       presc_tick;
    logic [3:0] pin_now;
    logic [3:0] pin_fall;
    logic [1:0] tick;
    logic [1:0] gate;
    logic [1:0] set_tf;
    logic       set_dcf;
    logic       set_go;
    logic       clr_go;
    logic       trig_hit;
    logic       path_ok;
    logic       expanded_ram_hit;
    logic [3:0] src_c;
    logic [3:0] dst_c;
    logic       ti;
    logic       tpage;
    logic [7:0] rd_mux;
    n          = q;
    en         = q.cr[sdma_pkg::CR_EN];
    loop_on    = q.cg[sdma_pkg::CG_LOOP];
    src_c      = q.ds[7:4];
    dst_c      = q.ds[3:0];
    set_tf     = 2'b00;
    set_dcf    = 1'b0;
    set_go     = 1'b0;
    clr_go     = 1'b0;
    trig_hit   = 1'b0;
    tick       = 2'b00;
    gate       = 2'b00;
    rd_mux     = 8'h00;
    n.src_rd   = 1'b0;
    n.dst_wr   = 1'b0;
    n.crc_wr   = 1'b0;

    // path check: both ends legal, never ram to ram or bus to bus
    path_ok  = src_ok(src_c) && dst_ok(dst_c)
             && !((src_c == sdma_pkg::PATH_EXPANDED_RAM)
                  && (dst_c == sdma_pkg::PATH_EXPANDED_RAM))
             && !((src_c == sdma_pkg::PATH_EMB)
                  && (dst_c == sdma_pkg::PATH_EMB));
    expanded_ram_hit = (src_c == sdma_pkg::PATH_EXPANDED_RAM) || (dst_c == sdma_pkg::PATH_EXPANDED_RAM);

    // divide-by-12 prescaler and falling edges of count inputs
    presc_tick = (q.presc == sdma_pkg::PRESC_LAST);
    n.presc    = presc_tick ? 4'h0 : q.presc + 4'h1;
    pin_now    = {evt_i.timer3_ext_input, evt_i.timer2_ext_input,
                  evt_i.address_pin, evt_i.count_pin};
    n.pin_prev = pin_now;
    pin_fall   = q.pin_prev & ~pin_now;

    // general timers, frozen while the dma owns them
    for (int i = 0; i < 2; i++) begin
      unique case (q.tcon[i][sdma_pkg::TC_CKS_HI:sdma_pkg::TC_CKS_LO])
        sdma_pkg::CKS_DIV12: tick[i] = presc_tick;
        sdma_pkg::CKS_PIN:   tick[i] = pin_fall[i];
        sdma_pkg::CKS_SYS:   tick[i] = 1'b1;
        sdma_pkg::CKS_EXT:   tick[i] = pin_fall[2 + i];
      endcase
      unique case (q.tcon[i][sdma_pkg::TC_GAT_HI:sdma_pkg::TC_GAT_LO])
        sdma_pkg::GAT_NONE: gate[i] = 1'b1;
        sdma_pkg::GAT_IRQ:  gate[i] = (i == 0) ? ~evt_i.ext_irq0_event
                                               : ~evt_i.ext_irq1_event;
        sdma_pkg::GAT_INT2: gate[i] = ~evt_i.ext_irq2_event;
        sdma_pkg::GAT_EXT:  gate[i] = (i == 0) ? evt_i.timer3_ext_input
                                               : evt_i.timer2_ext_input;
      endcase
      if (!en && q.tcon[i][sdma_pkg::TC_RUN] && tick[i] && gate[i]) begin
        if (q.cnt[i] == sdma_pkg::CNT_LAST) begin
          n.cnt[i]  = q.rld[i];
          set_tf[i] = 1'b1;
        end else begin
          n.cnt[i]  = q.cnt[i] + sdma_pkg::CNT_STEP;
        end
      end
    end

    // byte transaction sequencer: idle, fetch, store
    unique case (q.st)
      sdma_pkg::SDMA_IDLE: begin
        if (en && q.cr[sdma_pkg::CR_GO] && path_ok
            && src_ready_i && dst_ready_i) begin
          n.st     = sdma_pkg::SDMA_FETCH;
          n.src_rd = 1'b1;
        end
      end
      sdma_pkg::SDMA_FETCH: begin
        if (!en) begin
          n.st     = sdma_pkg::SDMA_IDLE;
        end else begin
          n.data   = src_data_i;
          n.dst_wr = 1'b1;
          n.crc_wr = q.cg[sdma_pkg::CG_CRC]
                   && (dst_c != sdma_pkg::PATH_CRC);
          n.st     = sdma_pkg::SDMA_STORE;
        end
      end
      sdma_pkg::SDMA_STORE: begin
        n.st = sdma_pkg::SDMA_IDLE;
        if (en) begin
          if (expanded_ram_hit) begin
            n.cnt[1] = q.cnt[1] + sdma_pkg::CNT_STEP;
          end
          if (q.cnt[0] == sdma_pkg::CNT_LAST) begin
            n.cnt[0] = q.rld[0];
            n.cnt[1] = q.rld[1];
            set_dcf  = 1'b1;
            clr_go   = !loop_on;
          end else begin
            n.cnt[0] = q.cnt[0] + sdma_pkg::CNT_STEP;
          end
        end
      end
      default: n.st = sdma_pkg::SDMA_IDLE;
    endcase
    if (clr_go) begin
      n.cr[sdma_pkg::CR_GO] = 1'b0;
    end

    // external start sources
    unique case (q.cg[sdma_pkg::CG_TRIG_HI:sdma_pkg::CG_TRIG_LO])
      sdma_pkg::TRIG_SW:   trig_hit = 1'b0;
      sdma_pkg::TRIG_INT2: trig_hit = evt_i.ext_irq2_event;
      sdma_pkg::TRIG_BRK:  trig_hit = evt_i.break_mod1_event;
      sdma_pkg::TRIG_KBI:  trig_hit = evt_i.keypad_event;
    endcase
    set_go = en && trig_hit;

    // register writes; reserved bits are dropped
    tpage = (sfr_req_i.page == sdma_pkg::PAGE_CNT)
          || (sfr_req_i.page == sdma_pkg::PAGE_ADR);
    ti    = (sfr_req_i.page == sdma_pkg::PAGE_ADR);
    if (sfr_req_i.wr) begin
      if (sfr_req_i.addr == sdma_pkg::ADDR_DMA) begin
        if (sfr_req_i.page <= sdma_pkg::PAGE_CR_LAST) begin
          n.cr = sfr_req_i.wdata & sdma_pkg::CR_MASK;
        end else if (sfr_req_i.page == sdma_pkg::PAGE_CG) begin
          n.cg = sfr_req_i.wdata & sdma_pkg::CG_MASK;
        end else if (sfr_req_i.page == sdma_pkg::PAGE_DS) begin
          n.ds = sfr_req_i.wdata;
        end
      end else if (tpage) begin
        unique case (sfr_req_i.addr)
          sdma_pkg::ADDR_TCON: n.tcon[ti] = sfr_req_i.wdata
                                          & sdma_pkg::TC_MASK;
          sdma_pkg::ADDR_TRL:  n.rld[ti][7:0]  = sfr_req_i.wdata;
          sdma_pkg::ADDR_TRH:  n.rld[ti][15:8] = sfr_req_i.wdata;
          sdma_pkg::ADDR_TCL:  n.cnt[ti][7:0]  = sfr_req_i.wdata;
          sdma_pkg::ADDR_TCH:  n.cnt[ti][15:8] = sfr_req_i.wdata;
          default: ;
        endcase
      end
    end

    // hardware sets win over a same-cycle software clear
    if (set_dcf) begin
      n.cr[sdma_pkg::CR_DONE] = 1'b1;
    end
    if (set_go) begin
      n.cr[sdma_pkg::CR_GO] = 1'b1;
    end
    for (int i = 0; i < 2; i++) begin
      if (set_tf[i]) begin
        n.tcon[i][sdma_pkg::TC_TF] = 1'b1;
      end
    end

    // read data, latched on the read strobe
    if (sfr_req_i.addr == sdma_pkg::ADDR_DMA) begin
      if (sfr_req_i.page <= sdma_pkg::PAGE_CR_LAST) begin
        rd_mux = q.cr;
      end else if (sfr_req_i.page == sdma_pkg::PAGE_CG) begin
        rd_mux = q.cg;
      end else if (sfr_req_i.page == sdma_pkg::PAGE_DS) begin
        rd_mux = q.ds;
      end
    end else if (tpage) begin
      unique case (sfr_req_i.addr)
        sdma_pkg::ADDR_TCON: rd_mux = q.tcon[ti];
        sdma_pkg::ADDR_TRL:  rd_mux = q.rld[ti][7:0];
        sdma_pkg::ADDR_TRH:  rd_mux = q.rld[ti][15:8];
        sdma_pkg::ADDR_TCL:  rd_mux = q.cnt[ti][7:0];
        sdma_pkg::ADDR_TCH:  rd_mux = q.cnt[ti][15:8];
        default:             rd_mux = 8'h00;
      endcase
    end
    if (sfr_req_i.rd) begin
      n.rdata = rd_mux;
    end

    // shared interrupt request and its priority
    n.irq  = (q.cr[sdma_pkg::CR_DONE] && q.cr[sdma_pkg::CR_IE])
           || (q.tcon[0][sdma_pkg::TC_TF]
               && q.tcon[0][sdma_pkg::TC_IE])
           || (q.tcon[1][sdma_pkg::TC_TF]
               && q.tcon[1][sdma_pkg::TC_IE]);
    n.prio = q.cg[sdma_pkg::CG_PRIO_HI:sdma_pkg::CG_PRIO_LO];
  end

  // state register, frozen while the clock enable is low
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      q <= sdma_pkg::REGS_RESET;
    end else if (ce_i) begin
      q <= n;
    end
  end

  // outputs straight from the state register
  assign sfr_rdata_o = q.rdata;
  assign src_sel_o   = q.ds[7:4];
  assign dst_sel_o   = q.ds[3:0];
  assign src_rd_o    = q.src_rd;
  assign dst_wr_o    = q.dst_wr;
  assign crc_wr_o    = q.crc_wr;
  assign xfer_data_o = q.data;
  assign expanded_ram_addr_o = q.cnt[1];
  assign irq_o       = q.irq;
  assign irq_prio_o  = q.prio;

  // checks on the engine
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_last_byte;
    ce_i && !sfr_req_i.wr && q.cr[sdma_pkg::CR_EN]
      && q.st == sdma_pkg::SDMA_STORE && q.cnt[0] == sdma_pkg::CNT_LAST;
  endsequence
  sequence s_fetching;
    ce_i && q.cr[sdma_pkg::CR_EN] && q.st == sdma_pkg::SDMA_FETCH;
  endsequence

  a_start_needs_go: assert property ($rose(src_rd_o) |->
      $past(q.cr[sdma_pkg::CR_EN]) && $past(q.cr[sdma_pkg::CR_GO]))
    else $error("read strobe without enable and go");
  a_byte_completes: assert property (s_fetching |=>
      dst_wr_o && q.st == sdma_pkg::SDMA_STORE)
    else $error("fetched byte was not stored");
  a_end_sets_done: assert property (s_last_byte |=>
      q.cr[sdma_pkg::CR_DONE] && q.cnt[0] == $past(q.rld[0]))
    else $error("end of transfer missed flag or reload");
  a_end_go_rule: assert property (s_last_byte
      ##0 (!evt_i.ext_irq2_event && !evt_i.break_mod1_event
           && !evt_i.keypad_event)
      |=> q.cr[sdma_pkg::CR_GO] == ($past(q.cg[sdma_pkg::CG_LOOP])
                                    && $past(q.cr[sdma_pkg::CR_GO])))
    else $error("go bit wrong after end of transfer");
  a_addr_reload: assert property (s_last_byte |=>
      expanded_ram_addr_o == $past(q.rld[1]))
    else $error("address not reloaded at end");
  a_done_sticky: assert property (ce_i && q.cr[sdma_pkg::CR_DONE]
      && !sfr_req_i.wr |=> q.cr[sdma_pkg::CR_DONE])
    else $error("completion flag dropped without write");
  a_irq_complete: assert property (ce_i && q.cr[sdma_pkg::CR_DONE]
      && q.cr[sdma_pkg::CR_IE] |=> irq_o)
    else $error("completion did not raise interrupt");
  a_prio_follow: assert property (ce_i |=>
      irq_prio_o == $past(q.cg[sdma_pkg::CG_PRIO_HI:sdma_pkg::CG_PRIO_LO]))
    else $error("priority does not follow configuration");
  a_crc_copy: assert property (crc_wr_o |->
      dst_wr_o && $past(q.cg[sdma_pkg::CG_CRC]))
    else $error("crc copy without store or enable");
  a_trig_irq2: assert property (ce_i && !sfr_req_i.wr
      && q.cr[sdma_pkg::CR_EN] && evt_i.ext_irq2_event
      && q.cg[sdma_pkg::CG_TRIG_HI:sdma_pkg::CG_TRIG_LO]
         == sdma_pkg::TRIG_INT2 |=> q.cr[sdma_pkg::CR_GO])
    else $error("irq2 trigger did not start");
  a_tf_sticky: assert property (ce_i && !sfr_req_i.wr
      && q.tcon[0][sdma_pkg::TC_TF] |=> q.tcon[0][sdma_pkg::TC_TF])
    else $error("count timer flag dropped");

  // per-byte steps, refusals and the timer flags
  sequence s_mid_byte;
    ce_i && !sfr_req_i.wr && q.cr[sdma_pkg::CR_EN]
      && q.st == sdma_pkg::SDMA_STORE && q.cnt[0] != sdma_pkg::CNT_LAST;
  endsequence
  a_count_step: assert property (s_mid_byte |=>
      q.cnt[0] == $past(q.cnt[0]) + sdma_pkg::CNT_STEP)
    else $error("transfer count did not step");
  a_addr_step: assert property (s_mid_byte ##0
      (src_sel_o == sdma_pkg::PATH_EXPANDED_RAM || dst_sel_o == sdma_pkg::PATH_EXPANDED_RAM)
      |=> expanded_ram_addr_o == $past(expanded_ram_addr_o) + sdma_pkg::CNT_STEP)
    else $error("ram address did not step");
  a_idle_when_off: assert property (ce_i && !q.cr[sdma_pkg::CR_EN]
      |=> !src_rd_o)
    else $error("read strobe while engine disabled");
  a_suspend_holds: assert property (ce_i && !q.cr[sdma_pkg::CR_GO]
      && q.st == sdma_pkg::SDMA_IDLE |=> !src_rd_o)
    else $error("transfer started while suspended");
  a_path_refused: assert property (ce_i
      && src_sel_o == sdma_pkg::PATH_EXPANDED_RAM
      && dst_sel_o == sdma_pkg::PATH_EXPANDED_RAM |=> !src_rd_o)
    else $error("ram to ram transfer started");
  a_tf6_sticky: assert property (ce_i && !sfr_req_i.wr
      && q.tcon[1][sdma_pkg::TC_TF] |=> q.tcon[1][sdma_pkg::TC_TF])
    else $error("address timer flag dropped");
  a_irq_cnt_tmr: assert property (ce_i
      && q.tcon[0][sdma_pkg::TC_TF] && q.tcon[0][sdma_pkg::TC_IE] |=> irq_o)
    else $error("count timer flag did not interrupt");
  a_irq_adr_tmr: assert property (ce_i
      && q.tcon[1][sdma_pkg::TC_TF] && q.tcon[1][sdma_pkg::TC_IE] |=> irq_o)
    else $error("address timer flag did not interrupt");
  a_no_crc_copy: assert property (ce_i && !q.cg[sdma_pkg::CG_CRC]
      && q.st == sdma_pkg::SDMA_FETCH |=> !crc_wr_o)
    else $error("crc copy while disabled");
endmodule : sdma_engine

// [sdma_far_model.sv]
// sdma_far_model: byte source and sink on the dma peripheral side
// assumes one byte is taken per read strobe; writes are always accepted unless slow_i stalls dst_ready_o
`timescale 1ns/1ps
module sdma_far_model (
  input  wire logic       clk_sys_i,
  input  wire logic       reset_n_i,
  input  wire logic       slow_i,
  input  wire logic [7:0] base_i,
  input  wire logic [7:0] budget_i,
  input  wire logic       src_rd_i,
  output logic            src_ready_o,
  output logic [7:0]      src_data_o,
  output logic            dst_ready_o,
  output logic [7:0]      served_o
);
  logic [7:0] lfsr_r;
  logic [7:0] byte_w;

  // served byte count and stall pattern
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      served_o <= 8'h00;
      lfsr_r   <= 8'h5a;
    end else begin
      lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
      if (src_rd_i) begin
        served_o <= served_o + 8'h01;
      end
    end
  end

  // byte valid only under the strobe, inverted between strobes
  assign byte_w      = base_i + served_o;
  assign src_data_o  = src_rd_i ? byte_w : ~byte_w;
  assign src_ready_o = (served_o != budget_i) && (!slow_i || lfsr_r[0]);
  assign dst_ready_o = !slow_i || lfsr_r[1];
endmodule : sdma_far_model

// [test_single_channel_dma_with_count_timers.sv]
// test_single_channel_dma_with_count_timers: self-checking bench
// assumes sdma_engine beside sdma_far_model on one 25 MHz clock
`timescale 1ns/1ps
module test_single_channel_dma_with_count_timers;
  logic                    clk_sys_i;
  logic                    reset_n_i;
  sdma_pkg::sdma_sfr_req_t sfr_req_i;
  sdma_pkg::sdma_events_t  evt_i;
  logic [7:0]              sfr_rdata_o, src_data_i, xfer_data_o, n;
  logic [7:0]              base, budget, served, nx;
  logic                    src_ready_i, dst_ready_i, src_rd_o, dst_wr_o;
  logic                    crc_wr_o, irq_o, slow, rd_tk;
  logic [3:0]              src_sel_o, dst_sel_o, pg;
  logic [15:0]             expanded_ram_addr_o, adr, abase;
  logic [1:0]              irq_prio_o, prio;
  logic [24:0]             exp_q[$];
  logic [7:0]              rd_q[$];
  int                      err_count = 0;
  int                      compares = 0;
  logic [3:0] rpg [9] = '{4'h0, 4'h8, 4'h9, 4'h3, 4'h3, 4'h3, 4'h3, 4'h3, 4'h4};
  logic [7:0] rad [9] = '{8'h94, 8'h94, 8'h94, 8'hc8, 8'hca, 8'hcb, 8'hcc,
                          8'hcd, 8'hc8};

  sdma_engine dut (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .ce_i(1'b1),
    .sfr_req_i(sfr_req_i), .sfr_rdata_o(sfr_rdata_o), .evt_i(evt_i),
    .src_ready_i(src_ready_i), .src_data_i(src_data_i),
    .dst_ready_i(dst_ready_i), .src_sel_o(src_sel_o), .dst_sel_o(dst_sel_o),
    .src_rd_o(src_rd_o), .dst_wr_o(dst_wr_o), .crc_wr_o(crc_wr_o),
    .xfer_data_o(xfer_data_o), .expanded_ram_addr_o(expanded_ram_addr_o), .irq_o(irq_o),
    .irq_prio_o(irq_prio_o));
  sdma_far_model far (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .slow_i(slow),
    .base_i(base), .budget_i(budget), .src_rd_i(src_rd_o),
    .src_ready_o(src_ready_i), .src_data_o(src_data_i),
    .dst_ready_o(dst_ready_i), .served_o(served));

  // system clock, 40 ns period
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input string nm, input logic [24:0] e,
                     input logic [24:0] s);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic close_out();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out

  // register bus cycles: one strobe cycle, then one idle cycle
  task automatic wr(input logic [3:0] p, input logic [7:0] a,
                    input logic [7:0] d);
    @(posedge clk_sys_i);
    sfr_req_i <= '{page: p, addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clk_sys_i);
    sfr_req_i.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] p, input logic [7:0] a,
                    input logic [7:0] e);
    @(posedge clk_sys_i);
    sfr_req_i <= '{page: p, addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    rd_q.push_back(e);
    @(posedge clk_sys_i);
    sfr_req_i.rd <= 1'b0;
  endtask : rd

  task automatic w16(input logic [3:0] p, input logic [7:0] a,
                     input logic [15:0] v);
    wr(p, a, v[7:0]);
    wr(p, a + 8'h01, v[15:8]);
  endtask : w16

  task automatic ctl(input logic [3:0] d);
    wr({1'b0, 3'($urandom())}, 8'h94, {4'h0, d});
  endtask : ctl

  task automatic pulse(input int t);
    @(posedge clk_sys_i);
    evt_i.ext_irq2_event   <= (t == 1);
    evt_i.break_mod1_event <= (t == 2);
    evt_i.keypad_event     <= (t == 3);
    @(posedge clk_sys_i);
    evt_i[6:4] <= 3'b000;
  endtask : pulse

  // expected bytes in order; the far side may serve up to this count
  task automatic note(input int k, input logic ram, input logic c);
    repeat (k) begin
      exp_q.push_back({c, adr, 8'(base + nx)});
      nx++;
      if (ram) adr++;
    end
    budget <= nx;
  endtask : note

  task automatic drain();
    for (int i = 0; i < 800 && exp_q.size() > 0; i++) @(posedge clk_sys_i);
    repeat (4) @(posedge clk_sys_i);
    chk("left", 25'h0, 25'(exp_q.size()));
  endtask : drain

  // result watcher: read data and byte transfers against the notes
  always @(posedge clk_sys_i) rd_tk <= sfr_req_i.rd;
  always @(negedge clk_sys_i) begin
    if (rd_tk) chk("read", {17'h0, rd_q.pop_front()}, {17'h0, sfr_rdata_o});
    if (dst_wr_o) chk("xfer", exp_q.pop_front(),
                      {crc_wr_o, expanded_ram_addr_o, xfer_data_o});
  end

  // hang guard, far beyond the longest expected run
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    err_count++;
    close_out();
  end

  // main sequence
  initial begin
    reset_n_i = 1'b0;
    sfr_req_i = '0;
    evt_i = '0;
    slow = 1'b0;
    budget = 8'h00;
    nx = 8'h00;
    void'($urandom(73244));
    base = 8'($urandom());
    abase = 16'($urandom());
    prio = 2'($urandom());
    repeat (10) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 9; i++) rd(rpg[i], rad[i], 8'h00);
    // software start, three bytes into ram with checksum copy
    wr(4'h8, 8'h94, {prio, 6'b10_0000});
    wr(4'h9, 8'h94, 8'h1f);
    w16(4'h3, 8'hcc, 16'hfffd);
    w16(4'h3, 8'hca, 16'hfffe);
    w16(4'h4, 8'hcc, abase);
    w16(4'h4, 8'hca, abase);
    adr = abase;
    note(3, 1'b1, 1'b1);
    ctl(4'he);
    drain();
    rd(4'h7, 8'h94, 8'h0b);
    chk("irq", 25'h1, {24'h0, irq_o});
    chk("prio", {23'h0, prio}, {23'h0, irq_prio_o});
    chk("path", 25'h1f, {17'h0, src_sel_o, dst_sel_o});
    rd(4'h3, 8'hcc, 8'hfe);
    rd(4'h4, 8'hcd, abase[15:8]);
    ctl(4'h8);
    rd(4'h0, 8'h94, 8'h08);
    // each external start source; a foreign event must not start
    wr(4'h9, 8'h94, 8'h12);
    adr = abase;
    for (int t = 1; t < 4; t++) begin
      wr(4'h8, 8'h94, {prio, 2'b00, 2'(t), 2'b00});
      ctl(4'h8);
      note(2, 1'b0, 1'b0);
      pulse(t % 3 + 1);
      repeat (8) @(posedge clk_sys_i);
      chk("idle", {17'h0, nx - 8'h02}, {17'h0, served});
      pulse(t);
      drain();
      rd(4'h5, 8'h94, 8'h09);
      chk("irq", 25'h0, {24'h0, irq_o});
    end
    // suspend mid-block with a stalling far side, then resume
    wr(4'h8, 8'h94, {prio, 6'b10_0000});
    wr(4'h9, 8'h94, 8'hf1);
    w16(4'h3, 8'hcc, 16'hfffc);
    adr = abase;
    note(4, 1'b1, 1'b1);
    slow <= 1'b1;
    ctl(4'hc);
    for (int i = 0; i < 200 && served == nx - 8'h04; i++) @(posedge clk_sys_i);
    ctl(4'h8);
    repeat (4) @(posedge clk_sys_i);
    n = served;
    repeat (30) @(posedge clk_sys_i);
    chk("held", {17'h0, n}, {17'h0, served});
    ctl(4'hc);
    drain();
    rd(4'h1, 8'h94, 8'h09);
    slow <= 1'b0;
    // loop mode: two passes of two bytes from a single start
    wr(4'h8, 8'h94, {prio, 6'b00_0001});
    wr(4'h9, 8'h94, 8'h1f);
    adr = abase;
    note(2, 1'b1, 1'b0);
    ctl(4'h8);
    adr = abase;
    note(2, 1'b1, 1'b0);
    ctl(4'hc);
    drain();
    rd(4'h2, 8'h94, 8'h0d);
    ctl(4'h0);
    budget <= nx + 8'h01;
    repeat (20) @(posedge clk_sys_i);
    chk("off", {17'h0, nx}, {17'h0, served});
    wr(4'h9, 8'h94, 8'hff);
    ctl(4'hc);
    repeat (20) @(posedge clk_sys_i);
    chk("ramram", {17'h0, nx}, {17'h0, served});
    ctl(4'h0);
    // both timers, every clock source, flag and shared request
    for (int k = 0; k < 2; k++) begin
      for (int c = 0; c < 4; c++) begin
        pg = k ? 4'h4 : 4'h3;
        w16(pg, 8'hca, 16'h0000);
        w16(pg, 8'hcc, 16'hffff);
        wr(pg, 8'hc8, {2'b00, 2'(c), 4'b1100});
        repeat (16) begin
          @(posedge clk_sys_i);
          evt_i[3:0] <= ~evt_i[3:0];
        end
        rd(pg, 8'hc8, {2'b10, 2'(c), 4'b1100});
        chk("irq", 25'h1, {24'h0, irq_o});
        wr(pg, 8'hc8, 8'h00);
        rd(pg, 8'hc8, 8'h00);
        chk("irq", 25'h0, {24'h0, irq_o});
      end
    end
    close_out();
  end
endmodule : test_single_channel_dma_with_count_timers
